// >>> rtl/gpio_ctrl_pkg.sv
// Functional notes
// - Enabled high-line condition sets summary status bit; the code counts it only on lines with direction zero (input)
// - Disabled line never sets summary bit
// - Debounce-disable zero keeps input filter active
// - Debounce-disable one passes level unfiltered
// - Output value zero drives line low
// - Output value one drives high per type
// - Drive type: zero push-pull, one open-drain
// - Line 6 bits reserved unless eleven-line variant
// - Condition is level matching selected polarity
// - Direction zero input, one output
// - High-line drive types in next register
package gpio_ctrl_pkg;
	localparam int LINE_COUNT = 11;
	localparam int LOW_LINES = 6;
	localparam int HIGH_LINES = 5;
	localparam int LINE6_BIT = 5;
	localparam int SUMMARY_BIT = 1;
	localparam logic [7:0] STATUS_OFFSET = 8'h01;
	localparam logic [7:0] IRQ_ENABLE_HIGH_OFFSET = 8'h20;
	localparam logic [7:0] DEBOUNCE_DISABLE_LOW_OFFSET = 8'h21;
	localparam logic [7:0] DEBOUNCE_DISABLE_HIGH_OFFSET = 8'h22;
	localparam logic [7:0] OUTPUT_VALUE_LOW_OFFSET = 8'h23;
	localparam logic [7:0] OUTPUT_VALUE_HIGH_OFFSET = 8'h24;
	localparam logic [7:0] DRIVE_TYPE_LOW_OFFSET = 8'h25;
	localparam logic [7:0] DRIVE_TYPE_HIGH_OFFSET = 8'h26;
	localparam logic [7:0] DIRECTION_LOW_OFFSET = 8'h27;
	localparam logic [7:0] DIRECTION_HIGH_OFFSET = 8'h28;
	localparam logic [LOW_LINES-1:0] LOW_RESET = 6'h00;
	localparam logic [HIGH_LINES-1:0] HIGH_RESET = 5'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam int DEBOUNCE_CYCLES_DEFAULT = 100;
endpackage

// >>> rtl/line_filter_if.sv
`timescale 1ns/1ps
interface line_filter_if;
	import gpio_ctrl_pkg::*;
	logic [LINE_COUNT-1:0] raw;
	logic [LINE_COUNT-1:0] bypass;
	logic [LINE_COUNT-1:0] clean;
	modport ctrl (output raw, output bypass, input clean);
	modport filter (input raw, input bypass, output clean);
endinterface

// >>> rtl/line_debounce.sv
`timescale 1ns/1ps
module line_debounce #(
	parameter int DEBOUNCE_CYCLES = gpio_ctrl_pkg::DEBOUNCE_CYCLES_DEFAULT
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Async reset, active low
	line_filter_if.filter lines // Raw pin levels in, filtered levels out
);
	import gpio_ctrl_pkg::*;
	localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LIMIT = CW'(DEBOUNCE_CYCLES - 1);

	logic [LINE_COUNT-1:0] meta_reg;
	logic [LINE_COUNT-1:0] sync_reg;
	logic [LINE_COUNT-1:0] clean_reg, clean_next;
	logic [CW-1:0] cnt_reg [LINE_COUNT];
	logic [CW-1:0] cnt_next [LINE_COUNT];

	always_comb
	begin
		for (int i = 0; i < LINE_COUNT; i++)
		begin
			clean_next[i] = clean_reg[i];
			cnt_next[i] = '0;
			if (lines.bypass[i])
				clean_next[i] = sync_reg[i];
			else if (sync_reg[i] != clean_reg[i])
			begin
				// Level must hold for the whole window before it is taken
				if (cnt_reg[i] == CNT_LIMIT)
					clean_next[i] = sync_reg[i];
				else
					cnt_next[i] = cnt_reg[i] + CW'(1);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
			clean_reg <= '0;
			for (int i = 0; i < LINE_COUNT; i++)
				cnt_reg[i] <= '0;
		end
		else
		begin
			meta_reg <= lines.raw;
			sync_reg <= meta_reg;
			clean_reg <= clean_next;
			for (int i = 0; i < LINE_COUNT; i++)
				cnt_reg[i] <= cnt_next[i];
		end
	end

	assign lines.clean = clean_reg;

	property p_bypass_follows;
		@(posedge clk_sys) disable iff (!rst_b)
		lines.bypass[0] |=> clean_reg[0] == $past(sync_reg[0]);
	endproperty
	a_bypass_follows: assert property (p_bypass_follows) else $error("bypassed line not passed");

	property p_filter_holds;
		@(posedge clk_sys) disable iff (!rst_b)
		(!lines.bypass[0] && sync_reg[0] != clean_reg[0] && cnt_reg[0] == '0)
			|=> clean_reg[0] == $past(clean_reg[0]);
	endproperty
	a_filter_holds: assert property (p_filter_holds) else $error("filter passed a fresh edge");
endmodule

// >>> rtl/gpio_irq_debounce_output_ctrl.sv
`timescale 1ns/1ps
module gpio_irq_debounce_output_ctrl #(
	parameter bit LINE6_PRESENT = 1'b1,
	parameter int DEBOUNCE_CYCLES = gpio_ctrl_pkg::DEBOUNCE_CYCLES_DEFAULT
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic reg_write, // Register write strobe from serial engine
	input wire logic [7:0] reg_addr, // Register offset
	input wire logic [7:0] reg_wdata, // Write data
	output logic [7:0] reg_rdata, // Read data, one cycle after address
	input wire logic [gpio_ctrl_pkg::HIGH_LINES-1:0] line_irq_polarity, // Lines 11..7 level
	input wire logic [gpio_ctrl_pkg::LINE_COUNT-1:0] gpio_in, // Pin levels
	output logic [gpio_ctrl_pkg::LINE_COUNT-1:0] gpio_out, // Pin drive value
	output logic [gpio_ctrl_pkg::LINE_COUNT-1:0] gpio_oe, // Pin drive enable
	output logic input_irq_summary_bit // Summary input interrupt status
);
	import gpio_ctrl_pkg::*;

	localparam logic [LOW_LINES-1:0] LOW_MASK = {LINE6_PRESENT, 5'h1F};

	logic [HIGH_LINES-1:0] irq_enable_reg, irq_enable_next;
	logic [LOW_LINES-1:0] deb_dis_low_reg, deb_dis_low_next;
	logic [HIGH_LINES-1:0] deb_dis_high_reg, deb_dis_high_next;
	logic [LOW_LINES-1:0] out_low_reg, out_low_next;
	logic [HIGH_LINES-1:0] out_high_reg, out_high_next;
	logic [LOW_LINES-1:0] type_low_reg, type_low_next;
	logic [HIGH_LINES-1:0] type_high_reg, type_high_next;
	logic [LOW_LINES-1:0] dir_low_reg, dir_low_next;
	logic [HIGH_LINES-1:0] dir_high_reg, dir_high_next;
	logic [7:0] rdata_next;
	logic summary_next;
	logic [LINE_COUNT-1:0] pin_out_next, pin_oe_next;
	logic [LINE_COUNT-1:0] data_all, type_all, dir_all;
	logic [HIGH_LINES-1:0] irq_condition;

	line_filter_if lines ();

	line_debounce #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_debounce (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.lines(lines)
	);

	function automatic logic [7:0] low_field(input logic [LOW_LINES-1:0] v);
		low_field = {2'h0, v & LOW_MASK};
	endfunction

	function automatic logic [7:0] high_field(input logic [HIGH_LINES-1:0] v);
		high_field = {3'h0, v};
	endfunction

	assign data_all = {out_high_reg, out_low_reg};
	assign type_all = {type_high_reg, type_low_reg};
	assign dir_all = {dir_high_reg, dir_low_reg};
	assign lines.raw = gpio_in;
	assign lines.bypass = {deb_dis_high_reg, deb_dis_low_reg};

	// Register writes; reserved and absent bits are dropped here
	always_comb
	begin
		irq_enable_next = irq_enable_reg;
		deb_dis_low_next = deb_dis_low_reg;
		deb_dis_high_next = deb_dis_high_reg;
		out_low_next = out_low_reg;
		out_high_next = out_high_reg;
		type_low_next = type_low_reg;
		type_high_next = type_high_reg;
		dir_low_next = dir_low_reg;
		dir_high_next = dir_high_reg;
		if (reg_write)
		begin
			case (reg_addr)
				IRQ_ENABLE_HIGH_OFFSET: irq_enable_next = reg_wdata[HIGH_LINES-1:0];
				DEBOUNCE_DISABLE_LOW_OFFSET: deb_dis_low_next = reg_wdata[LOW_LINES-1:0] & LOW_MASK;
				DEBOUNCE_DISABLE_HIGH_OFFSET: deb_dis_high_next = reg_wdata[HIGH_LINES-1:0];
				OUTPUT_VALUE_LOW_OFFSET: out_low_next = reg_wdata[LOW_LINES-1:0] & LOW_MASK;
				OUTPUT_VALUE_HIGH_OFFSET: out_high_next = reg_wdata[HIGH_LINES-1:0];
				DRIVE_TYPE_LOW_OFFSET: type_low_next = reg_wdata[LOW_LINES-1:0] & LOW_MASK;
				DRIVE_TYPE_HIGH_OFFSET: type_high_next = reg_wdata[HIGH_LINES-1:0];
				DIRECTION_LOW_OFFSET: dir_low_next = reg_wdata[LOW_LINES-1:0] & LOW_MASK;
				DIRECTION_HIGH_OFFSET: dir_high_next = reg_wdata[HIGH_LINES-1:0];
				default: ;
			endcase
		end
	end

	// Read mux; unmapped offsets answer zero
	always_comb
	begin
		case (reg_addr)
			STATUS_OFFSET: rdata_next = READ_ZERO | (8'(input_irq_summary_bit) << SUMMARY_BIT);
			IRQ_ENABLE_HIGH_OFFSET: rdata_next = high_field(irq_enable_reg);
			DEBOUNCE_DISABLE_LOW_OFFSET: rdata_next = low_field(deb_dis_low_reg);
			DEBOUNCE_DISABLE_HIGH_OFFSET: rdata_next = high_field(deb_dis_high_reg);
			OUTPUT_VALUE_LOW_OFFSET: rdata_next = low_field(out_low_reg);
			OUTPUT_VALUE_HIGH_OFFSET: rdata_next = high_field(out_high_reg);
			DRIVE_TYPE_LOW_OFFSET: rdata_next = low_field(type_low_reg);
			DRIVE_TYPE_HIGH_OFFSET: rdata_next = high_field(type_high_reg);
			DIRECTION_LOW_OFFSET: rdata_next = low_field(dir_low_reg);
			DIRECTION_HIGH_OFFSET: rdata_next = high_field(dir_high_reg);
			default: rdata_next = READ_ZERO;
		endcase
	end

	// Summary status follows enabled input conditions on lines 11..7
	always_comb
	begin
		for (int i = 0; i < HIGH_LINES; i++)
			irq_condition[i] = ~(lines.clean[LOW_LINES+i] ^ line_irq_polarity[i]);
		summary_next = |(irq_enable_reg & irq_condition & ~dir_high_reg);
	end

	// Pin drive: open drain only ever pulls low
	always_comb
	begin
		for (int i = 0; i < LINE_COUNT; i++)
		begin
			pin_out_next[i] = data_all[i] & ~type_all[i];
			pin_oe_next[i] = dir_all[i] & ~(type_all[i] & data_all[i]);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_enable_reg <= HIGH_RESET;
			deb_dis_low_reg <= LOW_RESET;
			deb_dis_high_reg <= HIGH_RESET;
			out_low_reg <= LOW_RESET;
			out_high_reg <= HIGH_RESET;
			type_low_reg <= LOW_RESET;
			type_high_reg <= HIGH_RESET;
			dir_low_reg <= LOW_RESET;
			dir_high_reg <= HIGH_RESET;
			reg_rdata <= READ_ZERO;
			input_irq_summary_bit <= 1'b0;
			gpio_out <= '0;
			gpio_oe <= '0;
		end
		else
		begin
			irq_enable_reg <= irq_enable_next;
			deb_dis_low_reg <= deb_dis_low_next;
			deb_dis_high_reg <= deb_dis_high_next;
			out_low_reg <= out_low_next;
			out_high_reg <= out_high_next;
			type_low_reg <= type_low_next;
			type_high_reg <= type_high_next;
			dir_low_reg <= dir_low_next;
			dir_high_reg <= dir_high_next;
			reg_rdata <= rdata_next;
			input_irq_summary_bit <= summary_next;
			gpio_out <= pin_out_next;
			gpio_oe <= pin_oe_next;
		end
	end

	property p_summary_set;
		@(posedge clk_sys) disable iff (!rst_b)
		(irq_enable_reg[0] && !dir_high_reg[0] && irq_condition[0]) |=> input_irq_summary_bit;
	endproperty
	a_summary_set: assert property (p_summary_set) else $error("enabled condition missed");

	property p_summary_cause;
		@(posedge clk_sys) disable iff (!rst_b)
		input_irq_summary_bit
			|-> |($past(irq_enable_reg) & $past(irq_condition) & ~$past(dir_high_reg));
	endproperty
	a_summary_cause: assert property (p_summary_cause) else $error("summary without cause");

	property p_polarity;
		@(posedge clk_sys) disable iff (!rst_b)
		irq_condition[0] == (lines.clean[LOW_LINES] == line_irq_polarity[0]);
	endproperty
	a_polarity: assert property (p_polarity) else $error("condition ignores polarity");

	property p_drive_low;
		@(posedge clk_sys) disable iff (!rst_b)
		(dir_all[0] && !data_all[0]) |=> (gpio_oe[0] && !gpio_out[0]);
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("zero value not driven low");

	property p_drive_high;
		@(posedge clk_sys) disable iff (!rst_b)
		(dir_all[7] && data_all[7] && !type_all[7]) |=> (gpio_oe[7] && gpio_out[7]);
	endproperty
	a_drive_high: assert property (p_drive_high) else $error("push-pull one not high");

	property p_open_drain;
		@(posedge clk_sys) disable iff (!rst_b)
		(type_all[8] && data_all[8]) |=> (!gpio_oe[8] && !gpio_out[8]);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

	property p_input_released;
		@(posedge clk_sys) disable iff (!rst_b)
		!dir_all[2] |=> !gpio_oe[2];
	endproperty
	a_input_released: assert property (p_input_released) else $error("input line driven");

	property p_line6_reserved;
		@(posedge clk_sys) disable iff (!rst_b)
		(reg_write && reg_addr == OUTPUT_VALUE_LOW_OFFSET)
			|=> out_low_reg[LINE6_BIT] == (LINE6_PRESENT && $past(reg_wdata[LINE6_BIT]));
	endproperty
	a_line6_reserved: assert property (p_line6_reserved) else $error("line 6 bit took a write");

	property p_reserved_zero;
		@(posedge clk_sys) disable iff (!rst_b)
		(reg_addr == IRQ_ENABLE_HIGH_OFFSET) |=> reg_rdata[7:HIGH_LINES] == 3'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");
endmodule

// >>> verif/pin_pad_model.sv
`timescale 1ns/1ps
module pin_pad_model (
	input wire logic [gpio_ctrl_pkg::LINE_COUNT-1:0] pin_out, // Device drive value
	input wire logic [gpio_ctrl_pkg::LINE_COUNT-1:0] pin_oe, // Device drive enable
	input wire logic [gpio_ctrl_pkg::LINE_COUNT-1:0] ext_level, // Outside circuit level
	input wire logic [gpio_ctrl_pkg::LINE_COUNT-1:0] ext_drive, // Outside circuit drives
	output logic [gpio_ctrl_pkg::LINE_COUNT-1:0] pad // Resolved pin level
);
	import gpio_ctrl_pkg::*;
	// Released pads follow the outside level when driven, else float up through the board pull-up
	always_comb
	begin
		for (int i = 0; i < LINE_COUNT; i++)
		begin
			pad[i] = pin_oe[i] ? pin_out[i] : (ext_drive[i] ? ext_level[i] : 1'b1);
		end
	end
endmodule

// >>> verif/gpio_irq_debounce_output_ctrl_tb.sv
`timescale 1ns/1ps
module gpio_irq_debounce_output_ctrl_tb;
	import gpio_ctrl_pkg::*;
	localparam int DEB = 4;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic reg_write = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [HIGH_LINES-1:0] line_irq_polarity = 5'h00;
	logic [LINE_COUNT-1:0] pad, gpio_out, gpio_oe, dir, val, mode, eoe;
	logic [LINE_COUNT-1:0] ext_level = 11'h000;
	logic [LINE_COUNT-1:0] ext_drive = 11'h7FF;
	logic input_irq_summary_bit;
	// Second device built as the ten-line variant
	logic [7:0] rdata_ten;
	logic [LINE_COUNT-1:0] out_ten, oe_ten;
	logic summary_ten;
	logic [31:0] seed = 32'h00012F2A;
	logic [7:0] shadow [9];
	logic [7:0] d;
	logic e;
	int n;
	int mismatches = 0;
	int check_count = 0;
	gpio_irq_debounce_output_ctrl #(.LINE6_PRESENT(1'b1), .DEBOUNCE_CYCLES(DEB))
		i_gpio_irq_debounce_output_ctrl (.clk_sys(clk_sys), .rst_b(rst_b),
		.reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .line_irq_polarity(line_irq_polarity), .gpio_in(pad),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .input_irq_summary_bit(input_irq_summary_bit));
	pin_pad_model i_pin_pad_model (.pin_out(gpio_out), .pin_oe(gpio_oe),
		.ext_level(ext_level), .ext_drive(ext_drive), .pad(pad));
	gpio_irq_debounce_output_ctrl #(.LINE6_PRESENT(1'b0), .DEBOUNCE_CYCLES(DEB))
		i_gpio_irq_debounce_output_ctrl_ten (.clk_sys(clk_sys), .rst_b(rst_b),
		.reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(rdata_ten), .line_irq_polarity(line_irq_polarity), .gpio_in(pad),
		.gpio_out(out_ten), .gpio_oe(oe_ten), .input_irq_summary_bit(summary_ten));
	always #4 clk_sys = ~clk_sys;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// Low registers hold six lines, high registers five
	function automatic logic [7:0] rd_mask(input logic [7:0] a);
		if (a == 8'h21 || a == 8'h23 || a == 8'h25 || a == 8'h27)
			return 8'h3F;
		if (a >= IRQ_ENABLE_HIGH_OFFSET && a <= DIRECTION_HIGH_OFFSET)
			return 8'h1F;
		return READ_ZERO;
	endfunction
	task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk_sys);
		reg_write = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(negedge clk_sys);
		reg_write = 1'b0;
	endtask
	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] m;
		m = (rd_mask(a) == 8'h3F) ? (exp & 8'h1F) : exp;
		@(negedge clk_sys);
		reg_addr = a;
		@(negedge clk_sys);
		check("reg_rdata", {3'h0, exp}, {3'h0, reg_rdata});
		check("reg_rdata_ten", {3'h0, m}, {3'h0, rdata_ten});
	endtask
	task automatic test_done();
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#400000;
		mismatches++;
		test_done();
	end
	initial
	begin
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_b = 1'b1;
		for (int a = 8'h1F; a <= 8'h29; a++)
			rd_check(8'(a), READ_ZERO);
		wr(STATUS_OFFSET, 8'hFF);
		rd_check(STATUS_OFFSET, READ_ZERO);
		for (int r = 0; r < 8; r++)
		begin
			for (int a = 0; a < 9; a++)
			begin
				seed = xs(seed);
				d = (r == 0) ? 8'hFF : ((r == 1) ? 8'h00 : seed[7:0]);
				shadow[a] = d & rd_mask(8'(8'h20 + a));
				wr(8'(8'h20 + a), d);
			end
			for (int a = 0; a < 9; a++)
				rd_check(8'(8'h20 + a), shadow[a]);
			repeat (3) @(negedge clk_sys);
			dir = {shadow[8][4:0], shadow[7][5:0]};
			val = {shadow[4][4:0], shadow[3][5:0]};
			mode = {shadow[6][4:0], shadow[5][5:0]};
			eoe = dir & ~(mode & val);
			check("gpio_oe", eoe, gpio_oe);
			check("gpio_out", val & eoe, gpio_out & eoe);
			check("line6 ten", 11'h000, {9'h0, oe_ten[LINE6_BIT], out_ten[LINE6_BIT]});
		end
		wr(DIRECTION_LOW_OFFSET, 8'h00);
		wr(DIRECTION_HIGH_OFFSET, 8'h00);
		wr(DEBOUNCE_DISABLE_LOW_OFFSET, 8'h3F);
		wr(DEBOUNCE_DISABLE_HIGH_OFFSET, 8'h1F);
		for (int k = 0; k < 16; k++)
		begin
			seed = xs(seed);
			d = (k == 0) ? 8'h00 : ((k == 1) ? 8'h1F : {3'h0, seed[4:0]});
			wr(IRQ_ENABLE_HIGH_OFFSET, d);
			@(negedge clk_sys);
			ext_level = seed[20:10];
			line_irq_polarity = (k < 2) ? seed[20:16] : seed[9:5];
			repeat (6) @(negedge clk_sys);
			e = |(d[4:0] & ~(line_irq_polarity ^ ext_level[10:6]));
			check("summary", {10'h0, e}, {10'h0, input_irq_summary_bit});
			check("summary ten", {10'h0, e}, {10'h0, summary_ten});
			rd_check(STATUS_OFFSET, {6'h00, e, 1'b0});
		end
		// Debounced lines: a short glitch is swallowed, a steady level passes late
		wr(DEBOUNCE_DISABLE_HIGH_OFFSET, 8'h00);
		wr(IRQ_ENABLE_HIGH_OFFSET, 8'h1F);
		@(negedge clk_sys);
		line_irq_polarity = 5'h1F;
		ext_level = 11'h000;
		repeat (20) @(negedge clk_sys);
		ext_level = 11'h7C0;
		repeat (DEB - 2) @(negedge clk_sys);
		ext_level = 11'h000;
		for (int c = 0; c < 15; c++)
		begin
			@(negedge clk_sys);
			check("glitch summary", 11'h000, {10'h0, input_irq_summary_bit});
		end
		ext_level = 11'h7C0;
		n = 0;
		while (input_irq_summary_bit !== 1'b1 && n < 40)
		begin
			@(negedge clk_sys);
			n++;
		end
		// Two sync stages, the filter window, then the summary register
		check("debounce delay", 11'(DEB + 3), 11'(n));
		test_done();
	end
endmodule
